// file: hw/adc_lane_ser.sv
// Purpose: one serial lane, holds a word and sends one bit per cycle
// Assumes: start marks the first bit of a frame, pos is valid with it
// Notes: runs on the link clock
`timescale 1ns/1ps
module adc_lane_ser
    import adc_out_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic start,
    input wire logic enable,
    input wire logic [13:0] word,
    input wire logic [3:0] pos,
    output logic data_out
);

    logic [13:0] word_q;
    logic data_q;

    // word held for the whole frame
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            word_q <= 14'h0000;
        else if (start)
            word_q <= word;
    end

    // bit picked at the position the frame counter gives
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            data_q <= 1'b0;
        else if (!enable)
            data_q <= 1'b0;
        else if (start)
            data_q <= word[pos];
        else
            data_q <= word_q[pos];
    end

    assign data_out = data_q;

endmodule : adc_lane_ser

// file: hw/adc_out_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, word-aligned registers
// Notes: included by the package user files by bare name
`ifndef ADC_OUT_PARAMS_SVH
`define ADC_OUT_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CONTROL 12'h000
`define OFF_CHAN_PD 12'h004
`define OFF_STATUS 12'h008

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTL_STANDBY 0
`define CTL_TWOS 1
`define CTL_LSB_FIRST 2
`define CTL_LOW_POWER 3
`define CTL_BOOST 4
`define CTL_PLL_LOW 5
`define CTL_RES_LO 6
`define CTL_RES_HI 7
`define CTL_PHASE_LO 8
`define CTL_PHASE_HI 10
`define CTL_BITS 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CONTROL_RST 11'h000
`define CHAN_PD_RST 4'h0

// ----------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------
`define LANES 4
`define WORD_BITS 14
`define CLK_MHZ 200
`define STANDBY_WAKE_NS 600
`define STANDBY_WAKE_CYC ((`STANDBY_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define PD_WAKE_US 375
`define PD_WAKE_CYC (`PD_WAKE_US * `CLK_MHZ)

`endif

// file: hw/adc_out_pkg.sv
// Purpose: shared types of the serial output block
// Assumes: nothing
// Notes: constants live in adc_out_params.svh
package adc_out_pkg;

    // output word length select
    typedef enum logic [1:0] {
        RES_14 = 2'b00,
        RES_12 = 2'b01,
        RES_10 = 2'b10,
        RES_8 = 2'b11
    } res_type;

    // power state of the device
    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_PIN_DOWN = 2'b01,
        PWR_STANDBY = 2'b10,
        PWR_WAKE = 2'b11
    } pwr_type;

endpackage : adc_out_pkg

// file: hw/adc_serial_out.sv
// Purpose: serial output, coding and power control of a quad converter
// Assumes: link_clk is the bit-rate clock, 14, 12, 10 or 8 periods per sample;
//          sample_word is synchronous to link_clk
// Notes: APB registers on pclk, lanes on link_clk
//
// Contract
// - power-down pin shuts reference, PLL, bias
// - pin power-down tri-states all output drivers
// - pin release resumes, settings kept
// - each channel powered down by register
// - standby keeps PLL, wakes in 600 ns
// - LVDS default, low power by pin/register
// - register boosts drive of all lanes
// - offset binary default, twos complement option
// - offset binary codes: 16383, 8192, 0
// - each channel on its own lane
// - lane bit rate fourteen times sample
// - PLL setting allows 5 MSPS sampling
// - bit clock seven times sample rate
// - frame clock marks each word start
// - MSB first default, LSB first option
// - bit clock phase 90 deg, 60 steps
// - 8, 10, 12-bit words shorten frame
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "adc_out_params.svh"
module adc_serial_out
    import adc_out_pkg::*;
#(
    parameter int unsigned PD_WAKE_CYC = `PD_WAKE_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_down_pin,
    input wire logic serial_io_drive_mode_pin,
    input wire logic link_clk,
    input wire logic [3:0][13:0] sample_word,
    output logic sample_take,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    output logic frame_clock_out,
    output logic frame_clock_oe,
    output logic core_power_down,
    output logic pll_power_down,
    output logic [3:0] channel_power_down,
    output logic low_power_drive,
    output logic drive_boost,
    output logic pll_low_rate,
    output logic [2:0] bit_clock_phase
);

    localparam int SB_CYC = `STANDBY_WAKE_CYC;
    localparam int LEN_FULL = `WORD_BITS;

    logic pd_meta_q, pd_q, odm_meta_q, odm_q;
    logic [`CTL_BITS-1:0] ctrl_q;
    logic [3:0] chpd_q;
    logic [31:0] prdata_q;
    logic setup, wr_acc, hit;
    pwr_type state_q;
    logic [16:0] wake_cnt_q;
    logic [8:0] cfg_src, cfg_meta_q, cfg_q;
    logic lrst_meta_q, lrst_n_q;
    logic [3:0] cnt_q, len, pos;
    logic [3:0] fcfg_q;
    logic start, last, on_l;
    logic [13:0] coded [4];
    logic [3:0] lane_oe_q;
    logic bclk_q, fclk_q, clk_oe_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_meta_q <= 1'b0;
            pd_q <= 1'b0;
            odm_meta_q <= 1'b0;
            odm_q <= 1'b0;
        end
        else
        begin
            pd_meta_q <= power_down_pin;
            pd_q <= pd_meta_q;
            odm_meta_q <= serial_io_drive_mode_pin;
            odm_q <= odm_meta_q;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign hit = (paddr == `OFF_CONTROL) || (paddr == `OFF_CHAN_PD) ||
                 (paddr == `OFF_STATUS);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_q;

    // settings; only presetn clears them, not the pin
    // settings survive pin power-down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `CONTROL_RST;
            chpd_q <= `CHAN_PD_RST;
        end
        else if (wr_acc && paddr == `OFF_CONTROL)
            ctrl_q <= pwdata[`CTL_BITS-1:0];
        else if (wr_acc && paddr == `OFF_CHAN_PD)
            chpd_q <= pwdata[3:0];
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            unique case (paddr)
                `OFF_CONTROL: prdata_q <= {21'h000000, ctrl_q};
                `OFF_CHAN_PD: prdata_q <= {28'h0000000, chpd_q};
                `OFF_STATUS: prdata_q <= {27'h0000000, odm_q, pd_q,
                                          state_q, state_q == PWR_ON};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    // pin forces full power-down
    // standby and its fixed wake time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= PWR_ON;
            wake_cnt_q <= 17'h00000;
        end
        else if (pd_q)
        begin
            state_q <= PWR_PIN_DOWN;
            // wake time grows with time spent down, up to PD_WAKE_CYC
            if (wake_cnt_q < 17'(PD_WAKE_CYC))
                wake_cnt_q <= wake_cnt_q + 17'h00001;
        end
        else if (ctrl_q[`CTL_STANDBY])
        begin
            state_q <= PWR_STANDBY;
            wake_cnt_q <= 17'(SB_CYC);
        end
        else
        begin
            unique case (state_q)
                PWR_ON: state_q <= PWR_ON;
                PWR_PIN_DOWN, PWR_STANDBY: state_q <= PWR_WAKE;
                PWR_WAKE:
                begin
                    if (wake_cnt_q <= 17'h00001)
                    begin
                        state_q <= PWR_ON;
                        wake_cnt_q <= 17'h00000;
                    end
                    else
                        wake_cnt_q <= wake_cnt_q - 17'h00001;
                end
            endcase
        end
    end

    // reference, bias and PLL off under the pin
    assign core_power_down = (state_q == PWR_PIN_DOWN) ||
                             (state_q == PWR_STANDBY);
    assign pll_power_down = state_q == PWR_PIN_DOWN;
    assign channel_power_down = chpd_q | {4{core_power_down}};
    // low power drive from pin or register
    assign low_power_drive = ctrl_q[`CTL_LOW_POWER] || odm_q;
    // one boost for all four lanes
    assign drive_boost = ctrl_q[`CTL_BOOST];
    assign pll_low_rate = ctrl_q[`CTL_PLL_LOW];
    // code 0 is 90 deg, each step 60 deg more
    assign bit_clock_phase = ctrl_q[`CTL_PHASE_HI:`CTL_PHASE_LO];

    // ------------------------------------------------------------
    // crossing into the link domain
    // ------------------------------------------------------------
    assign cfg_src = {state_q == PWR_ON, chpd_q, ctrl_q[`CTL_TWOS],
                      ctrl_q[`CTL_LSB_FIRST],
                      ctrl_q[`CTL_RES_HI:`CTL_RES_LO]};

    // reset release synchronised to the link clock
    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            lrst_meta_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end
        else
        begin
            lrst_meta_q <= 1'b1;
            lrst_n_q <= lrst_meta_q;
        end
    end

    // static settings, two flops per bit
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            cfg_meta_q <= 9'h000;
            cfg_q <= 9'h000;
        end
        else
        begin
            cfg_meta_q <= cfg_src;
            cfg_q <= cfg_meta_q;
        end
    end

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    assign on_l = cfg_q[8];
    assign len = 4'(LEN_FULL) - {1'b0, fcfg_q[1:0], 1'b0};
    assign start = cnt_q == 4'h0;
    assign last = cnt_q == len - 4'h1;
    assign pos = fcfg_q[2] ? cnt_q : len - 4'h1 - cnt_q;
    assign sample_take = start;

    // one bit per link cycle, len per sample (14, 12, 10 or 8)
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            cnt_q <= 4'h0;
            fcfg_q <= 4'h0;
        end
        else if (last)
        begin
            cnt_q <= 4'h0;
            fcfg_q <= cfg_q[3:0];
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end

    // all drivers released while powered down
    // bit clock toggles every bit, len/2 periods per word
    // frame clock high over first half of each word
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            bclk_q <= 1'b0;
            fclk_q <= 1'b0;
            clk_oe_q <= 1'b0;
            lane_oe_q <= 4'h0;
        end
        else
        begin
            bclk_q <= on_l && !cnt_q[0];
            fclk_q <= on_l && (cnt_q < {1'b0, len[3:1]});
            clk_oe_q <= on_l;
            lane_oe_q <= {4{on_l}} & ~cfg_q[7:4];
        end
    end

    assign bit_clock_out = bclk_q;
    assign frame_clock_out = fclk_q;
    assign bit_clock_oe = clk_oe_q;
    assign frame_clock_oe = clk_oe_q;
    assign lane_oe = lane_oe_q;

    // ------------------------------------------------------------
    // lanes
    // ------------------------------------------------------------
    // one serializer per channel
    for (genvar i = 0; i < `LANES; i++)
    begin : g_lane
        // twos complement flips the top bit
        // core word is offset binary already
        assign coded[i] = {sample_word[i][13] ^ fcfg_q[3],
                           sample_word[i][12:0]} >> {fcfg_q[1:0], 1'b0};
        adc_lane_ser u_lane (
            .link_clk(link_clk),
            .link_rst_n(lrst_n_q),
            .start(start),
            .enable(on_l && !cfg_q[4+i]),
            .word(coded[i]),
            .pos(pos),
            .data_out(lane_out[i])
        );
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pin_down;
        @(posedge pclk) disable iff (!presetn)
        pd_q |=> core_power_down && pll_power_down;
    endproperty
    a_pin_down: assert property (p_pin_down)
        else $error("pin power-down did not shut core and PLL");

    property p_hiz;
        @(posedge link_clk) disable iff (!lrst_n_q)
        !on_l |=> !bit_clock_oe && !frame_clock_oe && lane_oe == 4'h0;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("driver enabled while powered down");

    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        $fell(pd_q) |-> $stable(ctrl_q) && $stable(chpd_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("settings changed by leaving power-down");

    property p_chan_off;
        @(posedge link_clk) disable iff (!lrst_n_q)
        cfg_q[4] |=> !lane_oe[0] && !lane_out[0];
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("powered-down lane still active");

    property p_standby_wake;
        @(posedge pclk) disable iff (!presetn)
        (state_q == PWR_STANDBY && !pd_q && !ctrl_q[`CTL_STANDBY])
        |=> state_q == PWR_WAKE && !pll_power_down
        ##[SB_CYC:SB_CYC] state_q == PWR_ON;
    endproperty
    a_standby_wake: assert property (p_standby_wake)
        else $error("standby wake time wrong");

    property p_drive_pin;
        @(posedge pclk) disable iff (!presetn)
        $rose(serial_io_drive_mode_pin) |-> ##2 low_power_drive;
    endproperty
    a_drive_pin: assert property (p_drive_pin)
        else $error("drive-mode pin ignored");

    property p_frame_len;
        @(posedge link_clk) disable iff (!lrst_n_q)
        start && fcfg_q[1:0] == RES_14
        |-> ##1 !start [*8] ##1 !start [*5] ##1 start;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("full word frame not fourteen bits");

    property p_bit_clock;
        @(posedge link_clk) disable iff (!lrst_n_q)
        on_l && $past(on_l) |=> bit_clock_out != $past(bit_clock_out);
    endproperty
    a_bit_clock: assert property (p_bit_clock)
        else $error("bit clock missed a toggle");

    property p_frame_mark;
        @(posedge link_clk) disable iff (!lrst_n_q)
        start && on_l |=> frame_clock_out && bit_clock_out;
    endproperty
    a_frame_mark: assert property (p_frame_mark)
        else $error("frame clock not high at word start");

    property p_lsb_first;
        @(posedge link_clk) disable iff (!lrst_n_q)
        start && on_l && !cfg_q[4] && fcfg_q == 4'b0100
        |=> lane_out[0] == $past(sample_word[0][0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("first bit is not the LSB");

    property p_twos;
        @(posedge link_clk) disable iff (!lrst_n_q)
        start && on_l && !cfg_q[4] && fcfg_q == 4'b1000
        |=> lane_out[0] != $past(sample_word[0][13]);
    endproperty
    a_twos: assert property (p_twos)
        else $error("twos complement MSB not inverted");

    c_standby: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == PWR_STANDBY ##1 state_q == PWR_WAKE);
    c_pin: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(pll_power_down));
    c_short: cover property (@(posedge link_clk) disable iff (!lrst_n_q)
        start && on_l && fcfg_q[1:0] == RES_8);

endmodule : adc_serial_out

// file: test/adc_rx_model.sv
// Purpose: receiver at the far side of the four serial lanes
// Assumes: one lane bit per link_clk cycle, frame clock high at bit 0
// Notes: publishes the last whole word of each lane, its length and
//        the bit clock rises seen inside that frame
`timescale 1ns/1ps
module adc_rx_model
    import adc_out_pkg::*;
(
    input wire logic link_clk,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe,
    input wire logic bit_clock_out,
    input wire logic frame_clock_out,
    output logic [3:0][13:0] rx_word,
    output logic [4:0] rx_len,
    output logic [3:0] rx_edges
);
    logic [3:0][13:0] acc_q;
    logic [3:0] last_q;
    logic [3:0] lane_in;
    logic [4:0] cnt_q;
    logic [3:0] edge_q;
    logic fco_q;
    logic bco_q;
    logic frame_rise;
    logic bclk_rise;

    // -----------------------------------------------------------
    // wire levels
    // -----------------------------------------------------------
    // a released lane shows the inverse of its last level
    assign lane_in = (lane_out & lane_oe) | (~last_q & ~lane_oe);
    assign frame_rise = frame_clock_out & ~fco_q;
    assign bclk_rise = bit_clock_out & ~bco_q;

    // -----------------------------------------------------------
    // deserializer
    // -----------------------------------------------------------
    // one bit per link_clk cycle
    always_ff @(posedge link_clk)
    begin
        last_q <= lane_in;
        fco_q <= frame_clock_out;
        bco_q <= bit_clock_out;
        if (frame_rise)
        begin
            rx_word <= acc_q;
            rx_len <= cnt_q;
            rx_edges <= edge_q;
            for (int i = 0; i < 4; i++)
                acc_q[i] <= {13'h0000, lane_in[i]};
            cnt_q <= 5'h01;
            edge_q <= {3'h0, bclk_rise};
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                acc_q[i] <= {acc_q[i][12:0], lane_in[i]};
            cnt_q <= cnt_q + 5'h01;
            edge_q <= edge_q + {3'h0, bclk_rise};
        end
    end
endmodule : adc_rx_model

// file: test/adc_serial_output_and_power_down_tb.sv
// Purpose: self-checking bench of the serial output block
// Assumes: zero wait state APB, receiver model on the lanes
// Notes: short pin wake count to keep the run brief
`timescale 1ns/1ps
`include "adc_out_params.svh"
module adc_serial_output_and_power_down_tb
    import adc_out_pkg::*;
;
    localparam int unsigned WAKE = 200;
    typedef struct packed
    {
        logic [10:0] ctrl;
        logic [13:0] w;
        logic [4:0] len;
    } row_type;
    row_type rows [8];
    logic pclk, presetn, psel, penable, pwrite, link_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, errv, power_down_pin, serial_io_drive_mode_pin;
    logic [3:0][13:0] sample_word, rx_word;
    logic sample_take, bit_clock_out, bit_clock_oe, frame_clock_out;
    logic frame_clock_oe, core_power_down, pll_power_down;
    logic [3:0] lane_out, lane_oe, channel_power_down, rx_edges;
    logic low_power_drive, drive_boost, pll_low_rate;
    logic [2:0] bit_clock_phase;
    logic [4:0] rx_len;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    // -----------------------------------------------------------
    // clocks, timeout, instances
    // -----------------------------------------------------------
    always #2.5 pclk = ~pclk;
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    adc_serial_out #(.PD_WAKE_CYC(WAKE)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down_pin(power_down_pin),
        .serial_io_drive_mode_pin(serial_io_drive_mode_pin),
        .link_clk(link_clk), .sample_word(sample_word),
        .sample_take(sample_take), .lane_out(lane_out),
        .lane_oe(lane_oe), .bit_clock_out(bit_clock_out),
        .bit_clock_oe(bit_clock_oe), .frame_clock_out(frame_clock_out),
        .frame_clock_oe(frame_clock_oe),
        .core_power_down(core_power_down),
        .pll_power_down(pll_power_down),
        .channel_power_down(channel_power_down),
        .low_power_drive(low_power_drive), .drive_boost(drive_boost),
        .pll_low_rate(pll_low_rate), .bit_clock_phase(bit_clock_phase));
    adc_rx_model rx (.link_clk(link_clk), .lane_out(lane_out),
        .lane_oe(lane_oe), .bit_clock_out(bit_clock_out),
        .frame_clock_out(frame_clock_out), .rx_word(rx_word),
        .rx_len(rx_len), .rx_edges(rx_edges));

    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // one APB cycle, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rdchk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask : rdchk
    task automatic wait_ready();
        logic [31:0] rd;
        logic err;
        rd = 32'h0;
        for (int k = 0; k < 200 && rd[0] !== 1'b1; k++)
            apb(1'b0, `OFF_STATUS, 32'h0, rd, err);
    endtask : wait_ready
    task automatic wait_oe();
        for (int k = 0; k < 200 && lane_oe !== 4'hF; k++)
            @(posedge link_clk);
        repeat (60) @(posedge link_clk);
    endtask : wait_oe
    // expected received word: coding, length, bit order
    function automatic logic [13:0] expw(input logic [10:0] c,
        input logic [13:0] w);
        logic [13:0] v;
        logic [13:0] r;
        int l;
        l = 14 - 2 * int'(c[7:6]);
        v = (w ^ {c[1], 13'h0000}) >> (14 - l);
        r = v;
        if (c[2])
            for (int i = 0; i < l; i++)
                r[i] = v[l - 1 - i];
        return r;
    endfunction : expw

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, power_down_pin} = 4'h0;
        serial_io_drive_mode_pin = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_word = '0;
        rows = '{'{11'h000, 14'h2C35, 5'h0E}, '{11'h002, 14'h2000, 5'h0E},
            '{11'h004, 14'h2C35, 5'h0E}, '{11'h040, 14'h3FFF, 5'h0C},
            '{11'h080, 14'h0000, 5'h0A}, '{11'h0C6, 14'h2C35, 5'h08},
            '{11'h738, 14'h1FFF, 5'h0E}, '{11'h502, 14'h2C35, 5'h0E}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("control", `OFF_CONTROL, 32'h0);
        rdchk("status", `OFF_STATUS, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, rdv, errv);
        chk("slverr", 32'h1, 32'(errv));
        chk("unmapped", 32'h0, rdv);
        wait_oe();
        for (int r = 0; r < 8; r++)
        begin
            wr(`OFF_CONTROL, {21'h0, rows[r].ctrl});
            sample_word <= {14'h3FFE, 14'h1555, 14'h0001, rows[r].w};
            wait_oe();
            chk("len", 32'(rows[r].len), 32'(rx_len));
            chk("edges", 32'(rows[r].len / 2), 32'(rx_edges));
            for (int i = 0; i < 4; i++)
                chk("word", 32'(expw(rows[r].ctrl, sample_word[i])),
                    32'(rx_word[i]));
            chk("lowpw", 32'(rows[r].ctrl[3]), 32'(low_power_drive));
            chk("boost", 32'(rows[r].ctrl[4]), 32'(drive_boost));
            chk("pll", 32'(rows[r].ctrl[5]), 32'(pll_low_rate));
            chk("phase", 32'(rows[r].ctrl[10:8]),
                32'(bit_clock_phase));
        end
        wr(`OFF_CHAN_PD, 32'h5);
        repeat (20) @(posedge link_clk);
        chk("lane oe", 32'hA, 32'(lane_oe));
        chk("chan pd", 32'h5, 32'(channel_power_down));
        wr(`OFF_CHAN_PD, 32'h0);
        serial_io_drive_mode_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("drive pin", 32'h1, 32'(low_power_drive));
        serial_io_drive_mode_pin <= 1'b0;
        wr(`OFF_CONTROL, 32'h503);
        repeat (5) @(posedge pclk);
        chk("standby", 32'h2, {30'h0, core_power_down, pll_power_down});
        wr(`OFF_CONTROL, 32'h502);
        repeat (100) @(posedge pclk);
        rdchk("waking", `OFF_STATUS, 32'h6);
        repeat (30) @(posedge pclk);
        rdchk("awake", `OFF_STATUS, 32'h1);
        power_down_pin <= 1'b1;
        repeat (20) @(posedge link_clk);
        chk("pin pd", 32'h3, {30'h0, core_power_down, pll_power_down});
        chk("hi z", 32'h0, {26'h0, lane_oe, bit_clock_oe,
            frame_clock_oe});
        rdchk("down", `OFF_STATUS, 32'hA);
        power_down_pin <= 1'b0;
        wait_ready();
        rdchk("kept", `OFF_CONTROL, 32'h502);
        wait_oe();
        chk("resumed", 32'(expw(11'h502, 14'h2C35)), 32'(rx_word[0]));
        chk("oe", 32'h3F, {26'h0, lane_oe, bit_clock_oe,
            frame_clock_oe});
        @(posedge link_clk iff sample_take);
        @(posedge link_clk);
        chk("frame mark", 32'h3, {30'h0, frame_clock_out,
            bit_clock_out});
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("reset ctl", `OFF_CONTROL, 32'h0);
        test_done();
    end
endmodule : adc_serial_output_and_power_down_tb
